// >>> cto_pkg.sv
package cto_pkg;

    // ----------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------
    localparam logic [15:0] OP_MAC_FROM_ED   = 16'h27B1;
    localparam logic [15:0] OP_MAC_FROM_E    = 16'h27B2;
    localparam logic [15:0] OP_MAC_UNPACK    = 16'h27B3;
    localparam logic [15:0] OP_MAC_ROUND_E   = 16'h27B4;
    localparam logic [15:0] OP_MAC_TRUNC_E   = 16'h27B5;
    localparam logic [15:0] OP_EXT_BANK_B    = 16'h27BB;
    localparam logic [15:0] OP_STK_BANK_B    = 16'h37AF;
    localparam logic [15:0] OP_TST_IND8_X    = 16'h0006;
    localparam logic [15:0] OP_TST_IND8_Y    = 16'h0016;
    localparam logic [15:0] OP_TST_IND8_Z    = 16'h0026;
    localparam logic [15:0] OP_TST_IND16_X   = 16'h1706;
    localparam logic [15:0] OP_TST_IND16_Y   = 16'h1716;
    localparam logic [15:0] OP_TST_IND16_Z   = 16'h1726;
    localparam logic [15:0] OP_TST_EXT       = 16'h1736;
    localparam logic [15:0] OP_TST_A         = 16'h3706;
    localparam logic [15:0] OP_TST_B         = 16'h3716;
    localparam logic [15:0] OP_TST_D         = 16'h27F6;
    localparam logic [15:0] OP_TST_E         = 16'h2776;
    localparam logic [15:0] OP_FLAGS_FROM_D  = 16'h372D;
    localparam logic [15:0] OP_FLAGS_TO_A    = 16'h37FC;
    localparam logic [15:0] OP_FLAGS_TO_D    = 16'h372C;
    localparam logic [15:0] OP_E_TO_D        = 16'h27FB;

    // ----------------------------------------------------------------
    // Cycle counts
    // ----------------------------------------------------------------
    localparam logic [3:0] CYC_MAC_LOAD   = 4'h4;
    localparam logic [3:0] CYC_MAC_ROUND  = 4'h6;
    localparam logic [3:0] CYC_MAC_UNPACK = 4'h6;
    localparam logic [3:0] CYC_TST_MEM    = 4'h6;
    localparam logic [3:0] CYC_FLAGS_LOAD = 4'h4;
    localparam logic [3:0] CYC_SHORT      = 4'h2;

    // ----------------------------------------------------------------
    // Condition code fields
    // ----------------------------------------------------------------
    localparam int CCR_MV = 14;
    localparam int CCR_EV = 12;
    localparam int CCR_N  = 11;
    localparam int CCR_Z  = 10;
    localparam int CCR_V  = 9;
    localparam int CCR_SM = 4;

    localparam logic [15:0] SAT_POS    = 16'h7FFF;
    localparam logic [15:0] SAT_NEG    = 16'h8000;
    localparam logic [35:0] ROUND_BIAS = 36'h000008000;

    // ----------------------------------------------------------------
    // Addressing modes reported for memory tests
    // ----------------------------------------------------------------
    localparam logic [1:0] EA_NONE  = 2'h0;
    localparam logic [1:0] EA_IND8  = 2'h1;
    localparam logic [1:0] EA_IND16 = 2'h2;
    localparam logic [1:0] EA_EXT   = 2'h3;

    // ----------------------------------------------------------------
    // Register map and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_D      = 8'h08;
    localparam logic [7:0] ADDR_E      = 8'h0C;
    localparam logic [7:0] ADDR_X      = 8'h10;
    localparam logic [7:0] ADDR_CCR    = 8'h14;
    localparam logic [7:0] ADDR_MAC_LO = 8'h18;
    localparam logic [7:0] ADDR_MAC_HI = 8'h1C;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic       RST_ENABLE  = 1'b1;

    typedef struct packed {
        logic [15:0] d;
        logic [15:0] e;
        logic [15:0] x;
        logic [15:0] ccr;
        logic [35:0] mac;
    } cto_regs_s;

    localparam cto_regs_s RST_REGS = '0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } cto_state_e;

endpackage

// >>> cto_mac_round.sv
`timescale 1ns/1ps
module cto_mac_round (
    // Accumulator and mode
    input  wire logic [35:0] mac,
    input  wire logic        roundEn,
    input  wire logic        satMode,
    input  wire logic        mvIn,
    input  wire logic        evIn,
    // Result
    output logic      [15:0] eOut,
    output logic             mvOut,
    output logic             evOut
);
    import cto_pkg::*;

    logic [35:0] temp;

    // Bias is positive, so overflow only turns a positive value negative
    always_comb begin
        temp  = roundEn ? mac + ROUND_BIAS : mac;
        mvOut = roundEn ? (!mac[35] && temp[35]) : mvIn;
        evOut = roundEn ? !((&temp[35:31]) || !(|temp[35:31])) : evIn;
        if (satMode && (mvOut || evOut)) begin
            // Original sign chosen: temp sign is wrong after overflow
            eOut = mac[35] ? SAT_NEG : SAT_POS;
        end else begin
            eOut = temp[31:16];
        end
    end
endmodule

// >>> cto_core.sv
// Summary of operation
// [RULE1] 27B1: E:D into MAC low 32, sign-extend, clear MV/EV, 4 cycles
// [RULE2] 27B2: E into MAC 31:16, zero low half, sign-extend, clear MV/EV
// [RULE3] 27B4: round MAC; saturate or take bits 31:16 into E, 6 cycles
// [RULE4] Rounded transfer updates MV, EV, N and Z only
// [RULE5] 27B5: saturate or MAC 31:16 into E, N and Z only, 2 cycles
// [RULE6] 27B3: MAC into X (sign-extended high), E, D; no flags, 6 cycles
// [RULE7] 27BB: extension bank into B low nibble, B high nibble zero
// [RULE8] 37AF: stack bank into B low nibble, B high nibble zero
// [RULE9] Memory byte test sets N, Z, clears V; 8/16-bit/extended, 6 cycles
// [RULE10] 3706: test A, set N and Z, clear V, 2 cycles
// [RULE11] 3716: test B, set N and Z, clear V, 2 cycles
// [RULE12] 27F6: test D, set N and Z, clear V, 2 cycles
// [RULE13] 2776: test E, set N and Z, clear V, 2 cycles
// [RULE14] D into flags bits 15:4, program bank field kept
// [RULE15] Flags to A or D and E to D in 2 cycles; E to D sets N, Z
// [RULE16] Flag bits not named by an instruction keep their value; the code clears V on E to D
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module cto_core (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Instruction from fetch
    input  wire logic              opValid,
    input  wire logic [15:0]       opcode,
    input  wire logic [7:0]        memData,
    input  wire logic [3:0]        extBank,
    input  wire logic [3:0]        stackBank,
    output logic                   opReady,
    output logic                   opDone,
    output logic [1:0]             eaMode,
    output cto_pkg::cto_regs_s     regsOut,
    // AXI4-Lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import cto_pkg::*;

    cto_state_e  state;
    cto_regs_s   regs;
    cto_regs_s   next_regs;
    logic [15:0] curOp;
    logic [7:0]  curData;
    logic [3:0]  cnt;
    logic [3:0]  opCyc;
    logic        opKnown;
    logic        accept;
    logic        commit;
    logic        enable;
    logic        lastIllegal;
    logic [15:0] satE;
    logic        satMv;
    logic        satEv;
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    always_comb begin
        opKnown = 1'b1;
        case (opcode)
            OP_MAC_FROM_ED, OP_MAC_FROM_E: opCyc = CYC_MAC_LOAD;
            OP_MAC_ROUND_E:                opCyc = CYC_MAC_ROUND;
            OP_MAC_UNPACK:                 opCyc = CYC_MAC_UNPACK;
            OP_FLAGS_FROM_D:               opCyc = CYC_FLAGS_LOAD;
            OP_TST_IND8_X, OP_TST_IND8_Y, OP_TST_IND8_Z,
            OP_TST_IND16_X, OP_TST_IND16_Y, OP_TST_IND16_Z,
            OP_TST_EXT:                    opCyc = CYC_TST_MEM;
            OP_MAC_TRUNC_E, OP_EXT_BANK_B, OP_STK_BANK_B, OP_TST_A,
            OP_TST_B, OP_TST_D, OP_TST_E, OP_FLAGS_TO_A,
            OP_FLAGS_TO_D, OP_E_TO_D:      opCyc = CYC_SHORT;
            default: begin
                // Unknown codes pass as a short no-op
                opCyc   = CYC_SHORT;
                opKnown = 1'b0;
            end
        endcase
    end

    assign opReady = (state == ST_IDLE) && enable;
    assign accept  = opValid && opReady;
    assign commit  = (state == ST_EXEC) && (cnt == 4'h1);
    assign regsOut = regs;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
            cnt   <= 4'h0;
        end else begin
            unique case (state)
                ST_IDLE: if (accept) begin
                    state <= ST_EXEC;
                    cnt   <= opCyc - 4'h1;
                end
                ST_EXEC: begin
                    cnt <= cnt - 4'h1;
                    if (cnt == 4'h1) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            curOp       <= 16'h0000;
            curData     <= 8'h00;
            eaMode      <= EA_NONE;
            lastIllegal <= 1'b0;
        end else if (accept) begin
            curOp       <= opcode;
            curData     <= memData;
            lastIllegal <= !opKnown;
            // [RULE9] operand addressing
            case (opcode)
                OP_TST_IND8_X, OP_TST_IND8_Y, OP_TST_IND8_Z:
                    eaMode <= EA_IND8;
                OP_TST_IND16_X, OP_TST_IND16_Y, OP_TST_IND16_Z:
                    eaMode <= EA_IND16;
                OP_TST_EXT: eaMode <= EA_EXT;
                default:    eaMode <= EA_NONE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            opDone <= 1'b0;
        end else begin
            opDone <= commit;
        end
    end

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    // [RULE3] rounding and saturation
    cto_mac_round u_round (
        .mac     (regs.mac),
        .roundEn (curOp == OP_MAC_ROUND_E),
        .satMode (regs.ccr[CCR_SM]),
        .mvIn    (regs.ccr[CCR_MV]),
        .evIn    (regs.ccr[CCR_EV]),
        .eOut    (satE),
        .mvOut   (satMv),
        .evOut   (satEv)
    );

    // [RULE16] start from old flags
    always_comb begin
        next_regs = regs;
        case (curOp)
            // [RULE1] load from E and D
            OP_MAC_FROM_ED: begin
                next_regs.mac = {{4{regs.e[15]}}, regs.e, regs.d};
                next_regs.ccr[CCR_MV] = 1'b0;
                next_regs.ccr[CCR_EV] = 1'b0;
            end
            // [RULE2] load upper from E
            OP_MAC_FROM_E: begin
                next_regs.mac = {{4{regs.e[15]}}, regs.e, 16'h0000};
                next_regs.ccr[CCR_MV] = 1'b0;
                next_regs.ccr[CCR_EV] = 1'b0;
            end
            // [RULE4] rounded flag update
            OP_MAC_ROUND_E: begin
                next_regs.e = satE;
                next_regs.ccr[CCR_MV] = satMv;
                next_regs.ccr[CCR_EV] = satEv;
                next_regs.ccr[CCR_N]  = satE[15];
                next_regs.ccr[CCR_Z]  = (satE == 16'h0000);
            end
            // [RULE5] truncated transfer
            OP_MAC_TRUNC_E: begin
                next_regs.e = satE;
                next_regs.ccr[CCR_N] = satE[15];
                next_regs.ccr[CCR_Z] = (satE == 16'h0000);
            end
            // [RULE6] unpack to X, E, D
            OP_MAC_UNPACK: begin
                next_regs.x = {{12{regs.mac[35]}}, regs.mac[35:32]};
                next_regs.e = regs.mac[31:16];
                next_regs.d = regs.mac[15:0];
            end
            // [RULE7] extension bank
            OP_EXT_BANK_B: next_regs.d[7:0] = {4'h0, extBank};
            // [RULE8] stack bank
            OP_STK_BANK_B: next_regs.d[7:0] = {4'h0, stackBank};
            // [RULE9] memory byte test
            OP_TST_IND8_X, OP_TST_IND8_Y, OP_TST_IND8_Z,
            OP_TST_IND16_X, OP_TST_IND16_Y, OP_TST_IND16_Z,
            OP_TST_EXT: begin
                next_regs.ccr[CCR_N] = curData[7];
                next_regs.ccr[CCR_Z] = (curData == 8'h00);
                next_regs.ccr[CCR_V] = 1'b0;
            end
            // [RULE10] test A
            OP_TST_A: begin
                next_regs.ccr[CCR_N] = regs.d[15];
                next_regs.ccr[CCR_Z] = (regs.d[15:8] == 8'h00);
                next_regs.ccr[CCR_V] = 1'b0;
            end
            // [RULE11] test B
            OP_TST_B: begin
                next_regs.ccr[CCR_N] = regs.d[7];
                next_regs.ccr[CCR_Z] = (regs.d[7:0] == 8'h00);
                next_regs.ccr[CCR_V] = 1'b0;
            end
            // [RULE12] test D
            OP_TST_D: begin
                next_regs.ccr[CCR_N] = regs.d[15];
                next_regs.ccr[CCR_Z] = (regs.d == 16'h0000);
                next_regs.ccr[CCR_V] = 1'b0;
            end
            // [RULE13] test E
            OP_TST_E: begin
                next_regs.ccr[CCR_N] = regs.e[15];
                next_regs.ccr[CCR_Z] = (regs.e == 16'h0000);
                next_regs.ccr[CCR_V] = 1'b0;
            end
            // [RULE14] bank field kept
            OP_FLAGS_FROM_D: next_regs.ccr[15:4] = regs.d[15:4];
            // [RULE15] flag and E transfers
            OP_FLAGS_TO_A: next_regs.d[15:8] = regs.ccr[15:8];
            OP_FLAGS_TO_D: next_regs.d = regs.ccr;
            OP_E_TO_D: begin
                next_regs.d = regs.e;
                next_regs.ccr[CCR_N] = regs.e[15];
                next_regs.ccr[CCR_Z] = (regs.e == 16'h0000);
                next_regs.ccr[CCR_V] = 1'b0;
            end
            default: next_regs = regs;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            regs <= RST_REGS;
        end else if (commit) begin
            regs <= next_regs;
        end
    end

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    // Address and data may arrive in either order; held until both
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddr       <= 8'h00;
            wData        <= 32'h00000000;
            wStrb        <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            enable       <= RST_ENABLE;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (awHeld && wHeld && !s_axi_bvalid) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr[7:5] == 3'h0 && awAddr[1:0] == 2'h0)
                                ? RESP_OKAY : RESP_SLVERR;
                if (awAddr == ADDR_CTRL && wStrb[0]) begin
                    enable <= wData[0];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL:   s_axi_rdata <= {31'h00000000, enable};
                ADDR_STATUS: s_axi_rdata <= {30'h00000000, lastIllegal,
                                             state == ST_EXEC};
                ADDR_D:      s_axi_rdata <= {16'h0000, regs.d};
                ADDR_E:      s_axi_rdata <= {16'h0000, regs.e};
                ADDR_X:      s_axi_rdata <= {16'h0000, regs.x};
                ADDR_CCR:    s_axi_rdata <= {16'h0000, regs.ccr};
                ADDR_MAC_LO: s_axi_rdata <= regs.mac[31:0];
                ADDR_MAC_HI: s_axi_rdata <= {28'h0000000, regs.mac[35:32]};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_mac_load_ed: assert property ( // [RULE1]
        commit && curOp == OP_MAC_FROM_ED |=> regs.mac ==
        {{4{$past(regs.e[15])}}, $past(regs.e), $past(regs.d)} &&
        !regs.ccr[CCR_MV] && !regs.ccr[CCR_EV])
        else $error("mac load from E and D wrong");
    a_mac_load_e: assert property ( // [RULE2]
        accept && opcode == OP_MAC_FROM_E |=> state == ST_EXEC [*3]
        ##1 regs.mac[15:0] == 16'h0000 && !regs.ccr[CCR_EV]
        && regs.mac[35:32] == {4{regs.mac[31]}})
        else $error("mac load from E wrong");
    a_round_time: assert property ( // [RULE3]
        accept && opcode == OP_MAC_ROUND_E |=> state == ST_EXEC [*5]
        ##1 state == ST_IDLE && opDone)
        else $error("rounded transfer timing wrong");
    a_round_flags: assert property ( // [RULE4]
        commit && curOp == OP_MAC_ROUND_E |=>
        regs.ccr[CCR_N] == regs.e[15] && regs.ccr[CCR_V] ==
        $past(regs.ccr[CCR_V]) && regs.ccr[CCR_Z] == (regs.e == 16'h0000))
        else $error("rounded transfer flags wrong");
    a_trunc_sat: assert property ( // [RULE5]
        commit && curOp == OP_MAC_TRUNC_E && regs.ccr[CCR_SM] &&
        (regs.ccr[CCR_MV] || regs.ccr[CCR_EV]) |=>
        regs.e == ($past(regs.mac[35]) ? SAT_NEG : SAT_POS))
        else $error("truncated saturation wrong");
    a_unpack_x: assert property ( // [RULE6]
        commit && curOp == OP_MAC_UNPACK |=> regs.x[3:0] ==
        $past(regs.mac[35:32]) && regs.d == $past(regs.mac[15:0]) &&
        regs.ccr == $past(regs.ccr))
        else $error("unpack wrong");
    a_ext_bank: assert property ( // [RULE7]
        accept && opcode == OP_EXT_BANK_B |=> ##1 regs.d[7:0] ==
        {4'h0, $past(extBank)} && regs.ccr == $past(regs.ccr))
        else $error("extension bank copy wrong");
    a_stk_bank: assert property ( // [RULE8]
        commit && curOp == OP_STK_BANK_B |=>
        regs.d[7:0] == {4'h0, $past(stackBank)})
        else $error("stack bank copy wrong");
    a_tst_memory: assert property ( // [RULE9]
        accept && opcode == OP_TST_EXT |=> eaMode == EA_EXT ##5
        regs.ccr[CCR_N] == $past(curData[7], 5) && !regs.ccr[CCR_V])
        else $error("memory byte test wrong");
    a_tst_a: assert property ( // [RULE10]
        commit && curOp == OP_TST_A |=> regs.ccr[CCR_Z] ==
        (regs.d[15:8] == 8'h00) && !regs.ccr[CCR_V])
        else $error("test A wrong");
    a_tst_b: assert property ( // [RULE11]
        commit && curOp == OP_TST_B |=> regs.ccr[CCR_N] == regs.d[7]
        && regs.ccr[CCR_Z] == (regs.d[7:0] == 8'h00))
        else $error("test B wrong");
    a_tst_d: assert property ( // [RULE12]
        accept && opcode == OP_TST_D |=> state == ST_EXEC ##1
        state == ST_IDLE && regs.ccr[CCR_Z] == (regs.d == 16'h0000))
        else $error("test D wrong");
    a_tst_e: assert property ( // [RULE13]
        commit && curOp == OP_TST_E |=> regs.ccr[CCR_N] == regs.e[15]
        && !regs.ccr[CCR_V])
        else $error("test E wrong");
    a_flags_from_d: assert property ( // [RULE14]
        commit && curOp == OP_FLAGS_FROM_D |=> regs.ccr ==
        {$past(regs.d[15:4]), $past(regs.ccr[3:0])})
        else $error("flags from D wrong");
    a_e_to_d: assert property ( // [RULE15]
        commit && curOp == OP_E_TO_D |=> regs.d == $past(regs.e) &&
        regs.ccr[CCR_Z] == (regs.d == 16'h0000))
        else $error("E to D wrong");
    a_flags_kept: assert property ( // [RULE16]
        commit && curOp == OP_MAC_TRUNC_E |=>
        regs.ccr[15:12] == $past(regs.ccr[15:12]) &&
        regs.ccr[9:0] == $past(regs.ccr[9:0]))
        else $error("unnamed flags changed");
endmodule

// >>> cto_fetch_model.sv
`timescale 1ns/1ps
module cto_fetch_model (
    // Clock and handshake
    input  wire logic   clk,
    input  wire logic   opReady,
    input  wire logic   opDone,
    // Offered instruction
    output logic        opValid,
    output logic [15:0] opcode,
    output logic [7:0]  memData,
    output logic [3:0]  extBank,
    output logic [3:0]  stackBank
);
    initial begin
        opValid = 1'b0;
        opcode = 16'h0000;
        memData = 8'h00;
        extBank = 4'hA;
        stackBank = 4'h9;
    end
    // Offer held until taken, then scrambled so stale values never pass
    task automatic issue(input logic [15:0] op, input logic [7:0] md,
                         output int n);
        logic rdy;
        opValid <= 1'b1;
        opcode <= op;
        memData <= md;
        n = 0;
        // Ready looked at mid-cycle, where it is settled for the edge
        do begin
            @(negedge clk);
            rdy = opReady;
            @(posedge clk);
        end while (rdy !== 1'b1 && ++n < 50);
        opValid <= 1'b0;
        opcode <= ~op;
        memData <= ~md;
        if (n < 50) n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (opDone !== 1'b1 && n < 50);
        @(posedge clk);
    endtask
endmodule

// >>> cto_core_tb.sv
`timescale 1ns/1ps
module cto_core_tb;
    import cto_pkg::*;
    logic clk = 1'b0, reset = 1'b1;
    logic opValid, opReady, opDone, awv, awr, wv, wr, bv, br, arv, arr;
    logic rv, rr;
    logic [15:0] opcode;
    logic [7:0] memData, awa, ara;
    logic [3:0] extBank, stackBank;
    logic [1:0] eaMode, bresp, rresp;
    logic [31:0] wd, rd;
    cto_regs_s regsOut;
    int mismatches = 0, checks_done = 0;
    always #50 clk = ~clk;
    cto_fetch_model cto_fetch_model_i (.clk(clk), .opReady(opReady),
        .opDone(opDone), .opValid(opValid), .opcode(opcode),
        .memData(memData), .extBank(extBank), .stackBank(stackBank));
    cto_core cto_core_i (.clk(clk), .reset(reset), .opValid(opValid),
        .opcode(opcode), .memData(memData), .extBank(extBank),
        .stackBank(stackBank), .opReady(opReady), .opDone(opDone),
        .eaMode(eaMode), .regsOut(regsOut), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr));
    task automatic chk(input string nm, input logic [35:0] e, g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        logic [1:0] rsp;
        int n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(negedge clk);
            {aw, w, b, rsp} = {awr, wr, bv, bresp};
            @(posedge clk);
            if (aw) awv <= 1'b0;
            if (w) wv <= 1'b0;
        end while (b !== 1'b1 && ++n < 50);
        br <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            final_report;
        end
        chk("bresp", RESP_OKAY, rsp);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        logic ar, r;
        logic [1:0] rsp;
        logic [31:0] dat;
        int n = 0;
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(negedge clk);
            {ar, r, rsp, dat} = {arr, rv, rresp, rd};
            @(posedge clk);
            if (ar) arv <= 1'b0;
        end while (r !== 1'b1 && ++n < 50);
        rr <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            final_report;
        end
        chk("rresp", er, rsp);
        chk("rdata", e, dat);
    endtask
    task automatic run(input logic [15:0] op, input logic [7:0] md,
                       input int cy, input logic [15:0] ed, ec);
        int n;
        cto_fetch_model_i.issue(op, md, n);
        chk("cycles", 36'(cy), 36'(n));
        if (n >= 50) begin
            mismatches++;
            final_report;
        end
        chk("d", ed, regsOut.d);
        chk("ccr", ec, regsOut.ccr);
    endtask
    initial begin
        {awv, wv, br, arv, rr, awa, ara, wd} = '0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        axi_rd(ADDR_CTRL, 32'h1, RESP_OKAY);
        axi_rd(8'h20, 32'h0, RESP_SLVERR);
        axi_wr(ADDR_CTRL, 32'h0);
        chk("opReady", 1'b0, opReady);
        axi_wr(ADDR_CTRL, 32'h1);
        run(16'h27BB, 8'h00, 2, 16'h000A, 16'h0000);
        run(16'h27B1, 8'h00, 4, 16'h000A, 16'h0000);
        chk("mac", 36'h00000000A, regsOut.mac);
        run(16'h27B3, 8'h00, 6, 16'h000A, 16'h0000);
        chk("x", 36'h0, regsOut.x);
        run(16'h3716, 8'h00, 2, 16'h000A, 16'h0000);
        run(16'h3706, 8'h00, 2, 16'h000A, 16'h0400);
        run(16'h372C, 8'h00, 2, 16'h0400, 16'h0400);
        run(16'h0006, 8'h80, 6, 16'h0400, 16'h0800);
        chk("eaMode", EA_IND8, eaMode);
        run(16'h1736, 8'h00, 6, 16'h0400, 16'h0400);
        chk("eaMode", EA_EXT, eaMode);
        run(16'h37AF, 8'h00, 2, 16'h0409, 16'h0400);
        run(16'h372D, 8'h00, 4, 16'h0409, 16'h0400);
        run(16'h27F6, 8'h00, 2, 16'h0409, 16'h0000);
        run(16'h37FC, 8'h00, 2, 16'h0009, 16'h0000);
        run(16'h2776, 8'h00, 2, 16'h0009, 16'h0400);
        run(16'h27FB, 8'h00, 2, 16'h0000, 16'h0400);
        run(16'h27B2, 8'h00, 4, 16'h0000, 16'h0400);
        chk("mac", 36'h0, regsOut.mac);
        run(16'h27B5, 8'h00, 2, 16'h0000, 16'h0400);
        run(16'h27B4, 8'h00, 6, 16'h0000, 16'h0400);
        axi_rd(ADDR_CCR, 32'h0400, RESP_OKAY);
        run(16'hFFFF, 8'h00, 2, 16'h0000, 16'h0400);
        axi_rd(ADDR_STATUS, 32'h2, RESP_OKAY);
        final_report;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report;
    end
endmodule
